// File: src/twb_master.sv
// controlling end of the three-wire control bus
// assumes the returned data line is asynchronous and synchronises it
`timescale 1ns/10ps
module twb_master
  import twb_pkg::*;
#(
  parameter int STEP = STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus side
  twb_if.master bus,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  // response
  output logic rsp_valid,
  output logic [15:0] rsp_rdata
);
  import twb_pkg::*;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0000,
    M_START = 4'b0001,
    M_ALO = 4'b0010,
    M_AHI = 4'b0011,
    M_AEND = 4'b0100,
    M_DLO = 4'b0101,
    M_DHI = 4'b0110,
    M_DREL = 4'b0111,
    M_SGAP = 4'b1000,
    M_SPUL = 4'b1001,
    M_GAP = 4'b1010
  } twb_mst_t;

  logic dsy1_r, dsy2_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      dsy1_r <= 1'b1;
      dsy2_r <= 1'b1;
    end else begin
      dsy1_r <= bus.data_level;
      dsy2_r <= dsy1_r;
    end
  end

  // ---------------------------------------------------------------
  // sequencer: every step lasts STEP cycles, the longest least interval
  // ---------------------------------------------------------------
  twb_mst_t st_r, st_nxt;
  logic [15:0] div_r, div_nxt;
  logic [7:0] asr_r, asr_nxt, addr_r, addr_nxt;
  logic [15:0] dsr_r, dsr_nxt;
  logic [4:0] cnt_r, cnt_nxt, nbits;
  logic id_r, id_nxt, cl_r, cl_nxt, oe_r, oe_nxt;
  logic rdy_r, rdy_nxt, rv_r, rv_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic tick, wr;

  always_comb begin
    st_nxt = st_r;
    div_nxt = (div_r == 16'h0000) ? 16'(STEP - 1) : div_r - 16'h0001;
    asr_nxt = asr_r;
    addr_nxt = addr_r;
    dsr_nxt = dsr_r;
    cnt_nxt = cnt_r;
    id_nxt = id_r;
    cl_nxt = cl_r;
    oe_nxt = oe_r;
    rdy_nxt = rdy_r;
    rv_nxt = 1'b0;
    rd_nxt = rd_r;
    tick = (div_r == 16'h0000);
    nbits = addr_nbits(addr_r);
    wr = !addr_is_read(addr_r);
    case (st_r)
      M_IDLE: begin
        div_nxt = 16'(STEP - 1);
        if (cmd_valid && rdy_r) begin
          addr_nxt = cmd_addr;
          asr_nxt = cmd_addr;
          dsr_nxt = cmd_wdata;
          rdy_nxt = 1'b0;
          id_nxt = 1'b0;
          st_nxt = M_START;
        end
      end
      M_START: if (tick) begin
        cl_nxt = 1'b0;
        oe_nxt = !asr_r[0];
        cnt_nxt = 5'h00;
        st_nxt = M_ALO;
      end
      M_ALO: if (tick) begin
        cl_nxt = 1'b1;
        st_nxt = M_AHI;
      end
      M_AHI: if (tick) begin
        if (cnt_r == 5'(ADDR_BITS - 1)) begin
          id_nxt = 1'b1;
          oe_nxt = 1'b0;
          st_nxt = M_AEND;
        end else begin
          asr_nxt = {1'b0, asr_r[7:1]};
          oe_nxt = !asr_r[1];
          cl_nxt = 1'b0;
          cnt_nxt = cnt_r + 5'h01;
          st_nxt = M_ALO;
        end
      end
      M_AEND: if (tick) begin
        cl_nxt = 1'b0;
        oe_nxt = wr && !dsr_r[0];
        cnt_nxt = 5'h00;
        st_nxt = M_DLO;
      end
      M_DLO: if (tick) begin
        cl_nxt = 1'b1;
        st_nxt = M_DHI;
      end
      M_DHI: if (tick) begin
        dsr_nxt = {wr ? 1'b0 : dsy2_r, dsr_r[15:1]};
        cl_nxt = 1'b0;
        if (cnt_r == nbits - 5'h01) begin
          oe_nxt = 1'b0;
          st_nxt = M_DREL;
        end else begin
          oe_nxt = wr && !dsr_r[1];
          cnt_nxt = cnt_r + 5'h01;
          st_nxt = M_DLO;
        end
      end
      M_DREL: if (tick) begin
        cl_nxt = 1'b1;
        st_nxt = M_SGAP;
      end
      M_SGAP: if (tick) begin
        id_nxt = 1'b0;
        st_nxt = M_SPUL;
      end
      M_SPUL: if (tick) begin
        id_nxt = 1'b1;
        st_nxt = M_GAP;
      end
      M_GAP: if (tick) begin
        rv_nxt = 1'b1;
        rd_nxt = (nbits == 5'(DATA_BITS)) ? dsr_r : {8'h00, dsr_r[15:8]};
        rdy_nxt = 1'b1;
        st_nxt = M_IDLE;
      end
      default: begin
        st_nxt = M_IDLE;
        rdy_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= M_IDLE;
      div_r <= 16'h0000;
      asr_r <= 8'h00;
      addr_r <= 8'h00;
      dsr_r <= 16'h0000;
      cnt_r <= 5'h00;
      id_r <= 1'b1;
      cl_r <= 1'b1;
      oe_r <= 1'b0;
      rdy_r <= 1'b1;
      rv_r <= 1'b0;
      rd_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      asr_r <= asr_nxt;
      addr_r <= addr_nxt;
      dsr_r <= dsr_nxt;
      cnt_r <= cnt_nxt;
      id_r <= id_nxt;
      cl_r <= cl_nxt;
      oe_r <= oe_nxt;
      rdy_r <= rdy_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
    end
  end

  // master alone drives phase and clock lines
  assign bus.address_phase_signal = id_r;
  assign bus.serial_clock_line = cl_r;
  assign bus.mst_data_out = 1'b0;
  assign bus.mst_data_oe = oe_r;
  assign cmd_ready = rdy_r;
  assign rsp_valid = rv_r;
  assign rsp_rdata = rd_r;
endmodule

// File: src/twb_pkg.sv
// constants shared by both ends of the three-wire control bus
// assumes a single 40 mhz system clock on each end
package twb_pkg;
  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int BUS_F_MIN_HZ = 50;
  localparam int BUS_F_MAX_HZ = 170000;
  localparam int BUS_HALF_MIN_NS = 1000000000 / (2 * BUS_F_MAX_HZ);
  localparam int PAUSE_MAX_MS = 10;

  // ---------------------------------------------------------------
  // least signal intervals, in ns
  // ---------------------------------------------------------------
  localparam int T_IM1_NS = 0;
  localparam int T_IM2_NS = 3000;
  localparam int T_IM3_NS = 3000;
  localparam int T_IM4_NS = 0;
  localparam int T_IM5_NS = 1500;
  localparam int T_IM6_NS = 6000;
  localparam int T_IM7_NS = 0;
  localparam int T_IM8_NS = 0;
  localparam int T_IM9_NS = 0;
  localparam int T_IM10_NS = 3000;

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // every master step is as long as the longest interval, so each holds
  localparam int T_STEP_NS = imax(imax(imax(imax(T_IM1_NS, T_IM2_NS), imax(T_IM3_NS,
    T_IM4_NS)), imax(imax(T_IM5_NS, T_IM6_NS), imax(T_IM7_NS, T_IM8_NS))),
    imax(imax(T_IM9_NS, T_IM10_NS), BUS_HALF_MIN_NS));
  localparam int STEP_CYC = (T_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // framing and address layout
  // ---------------------------------------------------------------
  localparam int ADDR_BITS = 8;
  localparam int BYTE_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam int ADDR_RD_BIT = 0;
  localparam int ADDR_LEN_BIT = 1;
  localparam logic [7:0] SLV_ADDR_BASE = 8'h40;
  localparam logic [7:0] SLV_ADDR_MASK = 8'hfc;
  localparam logic [2:0] LINES_IDLE = 3'h7;
  localparam int LN_ID = 0;
  localparam int LN_CL = 1;
  localparam int LN_DA = 2;

  function automatic logic addr_is_read(input logic [7:0] a);
    return a[ADDR_RD_BIT];
  endfunction

  function automatic logic [4:0] addr_nbits(input logic [7:0] a);
    return a[ADDR_LEN_BIT] ? 5'(DATA_BITS) : 5'(BYTE_BITS);
  endfunction
endpackage

// File: src/twb_if.sv
// the three bus lines with open-drain resolution of the shared data line
// assumes one pull-up; both ends only ever pull data low
`timescale 1ns/10ps
interface twb_if;
  logic address_phase_signal;
  logic serial_clock_line;
  logic mst_data_out;
  logic mst_data_oe;
  logic slv_data_out;
  logic slv_data_oe;
  logic data_level;

  // wired-and with pull-up
  assign data_level = !(mst_data_oe && !mst_data_out) && !(slv_data_oe && !slv_data_out);

  modport master(
    output address_phase_signal,
    output serial_clock_line,
    output mst_data_out,
    output mst_data_oe,
    input data_level
  );
  modport slave(
    input address_phase_signal,
    input serial_clock_line,
    input data_level,
    output slv_data_out,
    output slv_data_oe
  );
endinterface

// File: src/twb_buf2.sv
// two-entry valid/ready buffer, head entry drives the output
// assumes producer and consumer on the same clock
`timescale 1ns/10ps
module twb_buf2 #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] head_r, head_nxt, tail_r, tail_nxt;
  logic hv_r, hv_nxt, tv_r, tv_nxt;
  logic pop, push;

  assign in_ready = !tv_r;
  assign out_valid = hv_r;
  assign out_data = head_r;

  always_comb begin
    pop = hv_r && out_ready;
    push = in_valid && !tv_r;
    head_nxt = head_r;
    tail_nxt = tail_r;
    hv_nxt = hv_r;
    tv_nxt = tv_r;
    if (pop) begin
      head_nxt = tail_r;
      hv_nxt = tv_r;
      tv_nxt = 1'b0;
    end
    if (push) begin
      if (!hv_nxt) begin
        head_nxt = in_data;
        hv_nxt = 1'b1;
      end else begin
        tail_nxt = in_data;
        tv_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head_r <= '0;
      tail_r <= '0;
      hv_r <= 1'b0;
      tv_r <= 1'b0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      hv_r <= hv_nxt;
      tv_r <= tv_nxt;
    end
  end
endmodule

// File: src/twb_slave.sv
// target end of the three-wire control bus
// assumes the bus lines come from another clock domain and are synchronised here
// Summary of operation
// - all three lines idle high
// - master opens with phase line then clock low
// - eight address bits, lsb first
// - target samples data at clock high
// - phase line rise triggers address compare
// - address selects read or write direction
// - eight or sixteen data pulses, lsb first
// - release data after last clock low
// - short phase-line low pulse commits data
// - survive pauses up to ten ms
// - master writes zeros, ignores unused bits
// - bus clock from 50 hz to 170 khz
// - only master drives phase and clock
// - data drivers are open-drain only
// - master keeps ten least intervals
`timescale 1ns/10ps
module twb_slave
  import twb_pkg::*;
#(
  parameter logic [7:0] ADDR_BASE = SLV_ADDR_BASE,
  parameter logic [7:0] ADDR_MASK = SLV_ADDR_MASK
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus side
  twb_if.slave bus,
  // committed writes
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data,
  // reads
  output logic rd_req,
  output logic [7:0] rd_addr,
  input wire logic [15:0] rd_data
);
  import twb_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ADDR = 2'b01,
    S_DATA = 2'b10,
    S_END = 2'b11
  } twb_sst_t;

  // ---------------------------------------------------------------
  // line synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] sy1_r, sy2_r, prv_r;
  logic id_fall, id_rise, cl_rise, cl_fall, din;

  always_ff @(posedge clk) begin
    if (rst) begin
      sy1_r <= LINES_IDLE;
      sy2_r <= LINES_IDLE;
      prv_r <= LINES_IDLE;
    end else begin
      sy1_r <= {bus.data_level, bus.serial_clock_line, bus.address_phase_signal};
      sy2_r <= sy1_r;
      prv_r <= sy2_r;
    end
  end

  assign id_fall = prv_r[LN_ID] && !sy2_r[LN_ID];
  assign id_rise = !prv_r[LN_ID] && sy2_r[LN_ID];
  assign cl_rise = !prv_r[LN_CL] && sy2_r[LN_CL];
  assign cl_fall = prv_r[LN_CL] && !sy2_r[LN_CL];
  assign din = sy2_r[LN_DA];

  // ---------------------------------------------------------------
  // transfer state
  // ---------------------------------------------------------------
  // no timeout anywhere: a stalled master may pause as long as it likes
  twb_sst_t st_r, st_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic oe_r, oe_nxt;
  logic rdq_r, rdq_nxt;
  logic [7:0] rda_r, rda_nxt;
  logic hit, push, buf_ready;
  logic [4:0] nbits;
  logic [15:0] word, wdata;

  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    oe_nxt = oe_r;
    rdq_nxt = 1'b0;
    rda_nxt = rda_r;
    push = 1'b0;
    nbits = addr_nbits(addr_r);
    word = (cnt_r == 5'h00) ? rd_data : sh_r;
    wdata = (nbits == 5'(DATA_BITS)) ? sh_r : {8'h00, sh_r[15:8]};
    // a full write buffer makes the target deaf to write addresses
    hit = ((addr_r & ADDR_MASK) == (ADDR_BASE & ADDR_MASK))
      && (addr_is_read(addr_r) || buf_ready);
    if (id_fall) begin
      // phase line low opens an address phase or is the closing pulse
      if (st_r == S_END && !addr_is_read(addr_r)) begin
        push = 1'b1;
      end
      st_nxt = S_ADDR;
      cnt_nxt = 5'h00;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        S_IDLE: begin
          oe_nxt = 1'b0;
        end
        S_ADDR: begin
          if (cl_rise && cnt_r < 5'(ADDR_BITS)) begin
            addr_nxt = {din, addr_r[7:1]};
            cnt_nxt = cnt_r + 5'h01;
          end
          if (id_rise) begin
            cnt_nxt = 5'h00;
            if (cnt_r == 5'(ADDR_BITS) && hit) begin
              st_nxt = S_DATA;
              rdq_nxt = addr_is_read(addr_r);
              rda_nxt = addr_r;
            end else begin
              st_nxt = S_IDLE;
            end
          end
        end
        S_DATA: begin
          if (addr_is_read(addr_r)) begin
            if (cl_fall) begin
              if (cnt_r == nbits) begin
                oe_nxt = 1'b0;
                st_nxt = S_END;
              end else begin
                oe_nxt = !word[0];
                sh_nxt = {1'b0, word[15:1]};
                cnt_nxt = cnt_r + 5'h01;
              end
            end
          end else if (cl_rise) begin
            sh_nxt = {din, sh_r[15:1]};
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == nbits - 5'h01) begin
              st_nxt = S_END;
            end
          end
        end
        S_END: begin
          oe_nxt = 1'b0;
        end
        default: begin
          st_nxt = S_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= S_IDLE;
      addr_r <= 8'h00;
      sh_r <= 16'h0000;
      cnt_r <= 5'h00;
      oe_r <= 1'b0;
      rdq_r <= 1'b0;
      rda_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      oe_r <= oe_nxt;
      rdq_r <= rdq_nxt;
      rda_r <= rda_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the target only ever pulls low; the pull-up makes the high
  assign bus.slv_data_out = 1'b0;
  assign bus.slv_data_oe = oe_r;
  assign rd_req = rdq_r;
  assign rd_addr = rda_r;

  twb_buf2 #(
    .W(ADDR_BITS + DATA_BITS)
  ) twb_buf2_inst (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data({addr_r, wdata}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );
endmodule

// File: verification/twb_checker.sv
// assertions on the three bus lines between the two ends
// assumes instantiation beside the interface, on the system clock of both ends
`timescale 1ns/10ps
module twb_checker
  import twb_pkg::*;
#(
  parameter int STEP = STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus lines
  input wire logic address_phase_signal,
  input wire logic serial_clock_line,
  input wire logic mst_data_out,
  input wire logic mst_data_oe,
  input wire logic slv_data_out,
  input wire logic slv_data_oe,
  input wire logic data_level
);
  // ---------------------------------------------------------------
  // edge counters
  // ---------------------------------------------------------------
  logic cl_q_r, cl_q_nxt;
  logic id_q_r, id_q_nxt;
  logic [4:0] acnt_r, acnt_nxt, dcnt_r, dcnt_nxt;
  logic [15:0] age_r, age_nxt;

  // acnt: clock rises in the phase-line low span, dcnt: rises while it is high
  always_comb begin
    cl_q_nxt = serial_clock_line;
    id_q_nxt = address_phase_signal;
    acnt_nxt = address_phase_signal ? 5'h00 : acnt_r;
    dcnt_nxt = dcnt_r;
    if (serial_clock_line && !cl_q_r) begin
      if (address_phase_signal) begin
        dcnt_nxt = dcnt_r + 5'h01;
      end else begin
        acnt_nxt = acnt_r + 5'h01;
      end
    end
    // every phase-line rise restarts the data count, so a closing pulse
    // leaves no stale count that makes the next opening look like a close
    if (address_phase_signal && !id_q_r) begin
      dcnt_nxt = 5'h00;
    end
    age_nxt = (serial_clock_line != cl_q_r) ? 16'h0000 :
      ((age_r == 16'hffff) ? age_r : age_r + 16'h0001);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cl_q_r <= 1'b1;
      id_q_r <= 1'b1;
      acnt_r <= 5'h00;
      dcnt_r <= 5'h00;
      age_r <= 16'hffff;
    end else begin
      cl_q_r <= cl_q_nxt;
      id_q_r <= id_q_nxt;
      acnt_r <= acnt_nxt;
      dcnt_r <= dcnt_nxt;
      age_r <= age_nxt;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_open;
    !address_phase_signal throughout (##[1:16] $fell(serial_clock_line));
  endsequence
  sequence s_close;
    (serial_clock_line && data_level) throughout (##[1:16] $rose(address_phase_signal));
  endsequence

  property p_od;
    !(mst_data_oe && mst_data_out) && !(slv_data_oe && slv_data_out);
  endproperty
  property p_one_drv;
    !(mst_data_oe && slv_data_oe);
  endproperty
  property p_addr_quiet;
    !address_phase_signal [*6] |-> !slv_data_oe;
  endproperty
  property p_rd_low;
    $changed(slv_data_oe) |-> !serial_clock_line;
  endproperty
  property p_hold_high;
    serial_clock_line && $past(serial_clock_line) && $stable(address_phase_signal)
      |-> $stable(data_level);
  endproperty
  property p_clk_step;
    $changed(serial_clock_line) |-> age_r >= 16'(STEP - 1);
  endproperty
  property p_addr_cnt;
    $rose(address_phase_signal) |-> acnt_r == 5'h00 || acnt_r == 5'h08;
  endproperty
  property p_data_cnt;
    $fell(address_phase_signal) |-> dcnt_r inside {5'h00, 5'h09, 5'h11};
  endproperty
  property p_open;
    $fell(address_phase_signal) && dcnt_r == 5'h00 |-> s_open;
  endproperty
  property p_close;
    $fell(address_phase_signal) && dcnt_r != 5'h00 |-> s_close;
  endproperty

  a_od: assert property (p_od) else $error("data driven high");
  a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
  a_addr_quiet: assert property (p_addr_quiet) else $error("target drives in address");
  a_rd_low: assert property (p_rd_low) else $error("read data moved at clock high");
  a_hold_high: assert property (p_hold_high) else $error("data moved at clock high");
  a_clk_step: assert property (p_clk_step) else $error("clock step too short");
  a_addr_cnt: assert property (p_addr_cnt) else $error("address bit count");
  a_data_cnt: assert property (p_data_cnt) else $error("data pulse count");
  a_open: assert property (p_open) else $error("no clock fall after start");
  a_close: assert property (p_close) else $error("closing pulse malformed");
endmodule

// File: verification/three_wire_control_bus_slave_tb.sv
// bench joining master and target ends across one bus interface
// assumes the package constants and a shortened master step of 8 cycles
`timescale 1ns/10ps
module three_wire_control_bus_slave_tb;
  import twb_pkg::*;
  localparam int STEP_TB = 8;
  int mismatches = 0;
  int num_checks = 0;
  int seed = 49;
  logic clk, rst, cmd_valid, cmd_ready, rsp_valid, wr_valid, wr_ready, rd_req, rnd_ready;
  logic cl_q, id_q;
  logic [7:0] cmd_addr, wr_addr, rd_addr, cur_addr, sh, a, ea;
  logic [2:0] lines;
  logic [15:0] cmd_wdata, rsp_rdata, wr_data, rd_data;
  logic [39:0] wq[$], e;
  logic [31:0] rq[$], r;
  logic [7:0] aq[$];
  int acnt;

  `define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end

  // ---------------------------------------------------------------
  // both ends on one bus
  // ---------------------------------------------------------------
  twb_if bus();
  assign lines = {bus.data_level, bus.serial_clock_line, bus.address_phase_signal};
  twb_master #(.STEP(STEP_TB)) twb_master_inst(.clk(clk), .rst(rst), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  twb_slave twb_slave_inst(.clk(clk), .rst(rst), .bus(bus), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data));
  twb_checker #(.STEP(STEP_TB)) twb_checker_inst(.clk(clk), .rst(rst),
    .address_phase_signal(bus.address_phase_signal), .serial_clock_line(bus.serial_clock_line),
    .mst_data_out(bus.mst_data_out), .mst_data_oe(bus.mst_data_oe),
    .slv_data_out(bus.slv_data_out), .slv_data_oe(bus.slv_data_oe),
    .data_level(bus.data_level));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // one transfer; expectations noted before the command goes out
  // ---------------------------------------------------------------
  task automatic xfer(input logic [7:0] ad, input logic [15:0] wd, input logic keep);
    logic [15:0] m;
    logic [15:0] rv;
    logic hit;
    int n;
    m = ad[ADDR_LEN_BIT] ? 16'hffff : 16'h00ff;
    rv = 16'($random(seed));
    hit = ((ad & SLV_ADDR_MASK) == SLV_ADDR_BASE);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    cur_addr = ad;
    if (ad[ADDR_RD_BIT]) begin
      rd_data <= rv;
      // a foreign read sees only the pull-up
      rq.push_back({m, hit ? (rv & m) : m});
      if (hit) aq.push_back(ad);
    end else begin
      rq.push_back(32'h0);
      if (hit && keep) wq.push_back({ad, m, wd & m});
    end
    cmd_valid <= 1'b1;
    cmd_addr <= ad;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) mismatches++;
  endtask

  // ---------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------
  initial begin
    cl_q = 1'b1;
    id_q = 1'b1;
    acnt = 0;
  end
  always @(posedge clk) begin
    if (rnd_ready) wr_ready <= 1'($random(seed));
    if (!rst) begin
      if (wr_valid && wr_ready) begin
        if (wq.size() == 0) `CHK("write entry", 1'b0, 1'b1)
        else begin
          e = wq.pop_front();
          `CHK("write addr", e[39:32], wr_addr)
          `CHK("write data", e[15:0], wr_data & e[31:16])
        end
      end
      if (rd_req) begin
        if (aq.size() == 0) `CHK("read request", 1'b0, 1'b1)
        else begin
          ea = aq.pop_front();
          `CHK("read addr", ea, rd_addr)
        end
      end
      if (rsp_valid && rq.size() == 0) `CHK("response", 1'b0, 1'b1)
      if (rsp_valid && rq.size() != 0) begin
        r = rq.pop_front();
        `CHK("read data", r[15:0], rsp_rdata & r[31:16])
        `CHK("idle lines", LINES_IDLE, lines)
      end
      // address bits as seen on the wire, lsb arriving first
      if (bus.serial_clock_line && !cl_q && !bus.address_phase_signal) begin
        sh = {bus.data_level, sh[7:1]};
        acnt++;
      end
      if (bus.address_phase_signal && !id_q) begin
        if (acnt == 8) `CHK("wire address", cur_addr, sh)
        acnt = 0;
      end
      cl_q = bus.serial_clock_line;
      id_q = bus.address_phase_signal;
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 16'h0000;
    wr_ready = 1'b1;
    rd_data = 16'h0000;
    rnd_ready = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) xfer(SLV_ADDR_BASE | 8'(i), 16'($random(seed)), 1'b1);
    $display("test modes done");
    for (int i = 0; i < 4; i++) xfer(8'h44 | 8'(i), 16'($random(seed)), 1'b1);
    $display("test foreign address done");
    // receiver stalls: two words held, the third write refused
    wr_ready <= 1'b0;
    xfer(8'h42, 16'($random(seed)), 1'b1);
    xfer(8'h40, 16'($random(seed)), 1'b1);
    xfer(8'h42, 16'($random(seed)), 1'b0);
    `CHK("buffer full", 1'b1, wr_valid)
    wr_ready <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("drained", 0, wq.size())
    $display("test stall done");
    rnd_ready = 1'b1;
    repeat (16) begin
      a = SLV_ADDR_BASE | (8'($random(seed)) & 8'h03);
      xfer(a, 16'($random(seed)), 1'b1);
    end
    rnd_ready = 1'b0;
    wr_ready <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("random drained", 0, wq.size())
    `CHK("reads answered", 0, aq.size() + rq.size())
    $display("test random done");
    print_verdict;
  end

  initial begin
    #2000000;
    mismatches++;
    $display("watchdog expired");
    print_verdict;
  end
endmodule
